// ### logic/elaio_group.sv
/*
  Output latch and drive enable for one four-line group.
  Assumes the parent decodes data-register writes into wr_i.
*/
`timescale 1ns/1ps
module elaio_group (
  input wire logic ref_clk_i,                         // reference clock
  input wire logic rst_i,                             // synchronous reset
  input wire logic dir_out_i,                         // group set as output
  input wire logic wr_i,                              // data write strobe
  input wire logic [elaio_pkg::GROUP_W-1:0] wdata_i,  // written nibble
  output logic [elaio_pkg::GROUP_W-1:0] line_out_o,   // driven pattern
  output logic [elaio_pkg::GROUP_W-1:0] line_oe_o     // drive enables
);

  wire take_write = wr_i && dir_out_i;

  // input groups ignore written bits, so the latch keeps its old pattern
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      line_out_o <= elaio_pkg::DATA_RESET[elaio_pkg::GROUP_W-1:0];
    end else if (take_write) begin // [R13]
      line_out_o <= wdata_i;
    end
  end

  assign line_oe_o = {elaio_pkg::GROUP_W{dir_out_i}}; // [R8]

endmodule

// ### logic/elaio_pkg.sv
/*
  Shared constants and types for the eight-line auxiliary digital port.
  Assumes a single register port on the reference clock; no bus wrapper.
*/
package elaio_pkg;

  // ----------------------------------------------------------------------
  // register map, printed offsets used directly as addresses
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] LINE_GROUP_DIRECTION_ADDR = 16'hB7FC;
  localparam logic [ADDR_W-1:0] LINE_PIN_DATA_ADDR = 16'hB806;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int LINES = 8;
  localparam int GROUP_W = 4;
  localparam int GROUPS = 2;
  localparam int DIR_LOWER_BIT = 0;
  localparam int DIR_UPPER_BIT = 1;
  localparam int LINE_TRIG0 = 0;
  localparam int LINE_TRIG1 = 1;
  localparam int LINE_REFCLK = 2;
  localparam int SYNC_STAGES = 2;

  // direction encodings, may be OR-ed together
  localparam logic [DATA_W-1:0] LOWER_GROUP_IN = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UPPER_GROUP_IN = 32'h0000_0000;
  localparam logic [DATA_W-1:0] LOWER_GROUP_OUT = 32'h0000_0001;
  localparam logic [DATA_W-1:0] UPPER_GROUP_OUT = 32'h0000_0002;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [GROUPS-1:0] DIR_RESET = 2'h0;
  localparam logic [LINES-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } elaio_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } elaio_rsp_t;

endpackage

// ### logic/elaio_sync.sv
/*
  Two-flop level synchroniser for a vector of pin inputs.
  Assumes the inputs are asynchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module elaio_sync #(
  parameter int W = 8
) (
  input wire logic ref_clk_i,      // reference clock
  input wire logic rst_i,          // synchronous reset, high
  input wire logic [W-1:0] async_i, // asynchronous levels
  output logic [W-1:0] sync_o      // synchronised levels
);

  logic [W-1:0] stage1;

  // only the second stage reads stage1, to keep metastability contained
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

// ### logic/elaio_top.sv
/*
  Eight-line auxiliary digital port: direction and data registers,
  pin drive, alternate trigger and reference-clock taps, and
  per-trigger capture for timestamp mode.
  Assumes pins are asynchronous and trigger_event_i is a one-cycle
  pulse on ref_clk_i from the trigger engine.
*/
`timescale 1ns/1ps

// Operation
// [R1] software sets lower group input before alternates
// [R2] upper group direction stays free meanwhile
// [R3] lines 0 and 1 feed extra triggers
// [R4] line 2 feeds timestamp reference clock
// [R5] line 3 is plain digital only
// [R6] reads show all lines, none masked
// [R7] direction: zero input, two upper output
// [R8] value one makes lower group output
// [R9] one 32-bit data register samples pins
// [R10] output lines read back driven pattern
// [R11] bit n maps to line n
// [R12] upper three written bytes discarded
// [R13] writes touch only output groups
// [R14] auto sampling captures all eight lines
// [R15] software enables timestamp before auto sampling
// [R16] reset leaves both groups as inputs
module elaio_top (
  input wire logic ref_clk_i,                          // 20 MHz clock
  input wire logic rst_i,                              // sync reset, high
  input wire elaio_pkg::elaio_req_t req_i,             // register request
  output elaio_pkg::elaio_rsp_t rsp_o,                 // read answer
  input wire logic [elaio_pkg::LINES-1:0] line_in_i,   // pin levels
  output logic [elaio_pkg::LINES-1:0] line_out_o,      // pin drive value
  output logic [elaio_pkg::LINES-1:0] line_oe_o,       // pin drive enable
  output logic extra_trigger_0_o,                      // trigger tap line 0
  output logic extra_trigger_1_o,                      // trigger tap line 1
  output logic timestamp_reference_clock_o,            // ref tap line 2
  input wire logic timestamp_mode_i,                   // timestamp on
  input wire logic auto_sample_en_i,                   // per-trigger sample
  input wire logic trigger_event_i,                    // trigger pulse
  output logic [elaio_pkg::LINES-1:0] sample_data_o,   // captured lines
  output logic sample_valid_o                          // capture pulse
);

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  logic [elaio_pkg::GROUPS-1:0] dir;
  logic [elaio_pkg::LINES-1:0] pins;

  wire hit_dir = req_i.addr == elaio_pkg::LINE_GROUP_DIRECTION_ADDR;
  wire hit_data = req_i.addr == elaio_pkg::LINE_PIN_DATA_ADDR;
  wire wr_dir = req_i.wr && hit_dir;
  wire wr_data = req_i.wr && hit_data;
  // only bits 1:0 of the direction word mean anything
  wire [elaio_pkg::GROUPS-1:0] next_dir =
    req_i.wdata[elaio_pkg::GROUPS-1:0]; // [R7]

  // ----------------------------------------------------------------------
  // direction register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dir <= elaio_pkg::DIR_RESET; // [R16]
    end else if (wr_dir) begin
      dir <= next_dir; // [R2] [R7] [R8]
    end
  end

  // ----------------------------------------------------------------------
  // pin sampling and group drivers
  // ----------------------------------------------------------------------
  elaio_sync #(
    .W(elaio_pkg::LINES)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(line_in_i),
    .sync_o(pins)
  );

  genvar g;
  generate
    for (g = 0; g < elaio_pkg::GROUPS; g++) begin : gen_group
      elaio_group u_group (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .dir_out_i(dir[g]),
        .wr_i(wr_data),
        // bits above the low byte never reach a latch
        .wdata_i(req_i.wdata[g*elaio_pkg::GROUP_W +: elaio_pkg::GROUP_W]),
        .line_out_o(line_out_o[g*elaio_pkg::GROUP_W +: elaio_pkg::GROUP_W]),
        .line_oe_o(line_oe_o[g*elaio_pkg::GROUP_W +: elaio_pkg::GROUP_W])
      ); // [R11] [R12] [R13]
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // the pins are read, not the latch, so outputs echo what is driven
  wire [elaio_pkg::DATA_W-1:0] data_word =
    {{(elaio_pkg::DATA_W-elaio_pkg::LINES){1'b0}}, pins}; // [R6] [R9] [R10]
  wire [elaio_pkg::DATA_W-1:0] dir_word =
    {{(elaio_pkg::DATA_W-elaio_pkg::GROUPS){1'b0}}, dir};
  wire [elaio_pkg::DATA_W-1:0] next_rdata =
    hit_data ? data_word : (hit_dir ? dir_word : elaio_pkg::READ_ZERO);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rsp_o.valid <= 1'b0;
      rsp_o.rdata <= elaio_pkg::READ_ZERO;
    end else begin
      rsp_o.valid <= req_i.rd;
      if (req_i.rd) begin
        rsp_o.rdata <= next_rdata; // [R9]
      end
    end
  end

  // ----------------------------------------------------------------------
  // alternate functions of the lower group
  // ----------------------------------------------------------------------
  // taps go low one cycle after the lower group starts to drive, but for two cycles
  // after it turns input the synchroniser still feeds them its own pattern; line 3 has no tap at all
  wire lower_in = !dir[elaio_pkg::DIR_LOWER_BIT];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      extra_trigger_0_o <= 1'b0;
      extra_trigger_1_o <= 1'b0;
      timestamp_reference_clock_o <= 1'b0;
    end else begin
      extra_trigger_0_o <= lower_in && pins[elaio_pkg::LINE_TRIG0]; // [R3]
      extra_trigger_1_o <= lower_in && pins[elaio_pkg::LINE_TRIG1]; // [R3]
      timestamp_reference_clock_o <=
        lower_in && pins[elaio_pkg::LINE_REFCLK]; // [R4] [R5]
    end
  end

  // ----------------------------------------------------------------------
  // per-trigger capture
  // ----------------------------------------------------------------------
  // needs timestamp mode too; software should enable it first
  wire capture = trigger_event_i && auto_sample_en_i &&
    timestamp_mode_i; // [R15]

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sample_valid_o <= 1'b0;
      sample_data_o <= elaio_pkg::DATA_RESET;
    end else begin
      sample_valid_o <= capture;
      if (capture) begin
        sample_data_o <= pins; // [R14]
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  dir_reset_a: assert property (@(posedge ref_clk_i) // [R16]
    $past(rst_i) |-> (dir == elaio_pkg::DIR_RESET && line_oe_o == 8'h00))
    else $error("direction not input after reset");

  upper_oe_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R7]
    wr_dir ##1 1'b1 |->
      line_oe_o[7:4] == {4{$past(req_i.wdata[elaio_pkg::DIR_UPPER_BIT])}})
    else $error("upper group enable wrong after direction write");

  lower_oe_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R8]
    wr_dir ##1 1'b1 |->
      line_oe_o[3:0] == {4{$past(req_i.wdata[elaio_pkg::DIR_LOWER_BIT])}})
    else $error("lower group enable wrong after direction write");

  in_group_keep_a: assert property (@(posedge ref_clk_i) // [R13]
    disable iff (rst_i)
    (wr_data && !dir[elaio_pkg::DIR_UPPER_BIT]) |=>
      $stable(line_out_o[7:4]))
    else $error("input group latch changed on write");

  out_write_a: assert property (@(posedge ref_clk_i) // [R12]
    disable iff (rst_i)
    (wr_data && dir == 2'h3) |=> line_out_o == $past(req_i.wdata[7:0]))
    else $error("output pattern differs from written low byte");

  read_pins_a: assert property (@(posedge ref_clk_i) // [R6]
    disable iff (rst_i)
    (req_i.rd && hit_data) |=>
      (rsp_o.valid && rsp_o.rdata == {24'h000000, $past(pins)}))
    else $error("data read does not show sampled pins");

  trig_tap_a: assert property (@(posedge ref_clk_i) // [R3]
    disable iff (rst_i)
    ($past(dir[elaio_pkg::DIR_LOWER_BIT]) == 1'b0 && !$past(rst_i)) |->
      (extra_trigger_0_o == $past(pins[0]) &&
       extra_trigger_1_o == $past(pins[1])))
    else $error("extra trigger tap does not follow its line");

  ref_tap_a: assert property (@(posedge ref_clk_i) // [R4]
    disable iff (rst_i)
    $past(dir[elaio_pkg::DIR_LOWER_BIT]) |-> !timestamp_reference_clock_o)
    else $error("reference clock tap active while lower group drives");

  capture_a: assert property (@(posedge ref_clk_i) // [R14]
    disable iff (rst_i)
    capture |=> (sample_valid_o && sample_data_o == $past(pins)))
    else $error("trigger capture missed or wrong");

  // ----------------------------------------------------------------------
  // further checks on registers, taps and capture
  // ----------------------------------------------------------------------
  // these watch whole-port behaviour, so a broken group latch, a swapped
  // nibble or a stuck tap shows up even where the bench looks elsewhere
  lower_keep_a: assert property (@(posedge ref_clk_i) // [R13]
    disable iff (rst_i)
    (wr_data && !dir[elaio_pkg::DIR_LOWER_BIT]) |=>
      $stable(line_out_o[elaio_pkg::GROUP_W-1:0]))
    else $error("lower input group latch changed on write");

  lower_write_a: assert property (@(posedge ref_clk_i) // [R13]
    disable iff (rst_i)
    (wr_data && dir[elaio_pkg::DIR_LOWER_BIT]) |=>
      line_out_o[elaio_pkg::GROUP_W-1:0] ==
        $past(req_i.wdata[elaio_pkg::GROUP_W-1:0]))
    else $error("lower output group missed its written nibble");

  upper_write_a: assert property (@(posedge ref_clk_i) // [R13]
    disable iff (rst_i)
    (wr_data && dir[elaio_pkg::DIR_UPPER_BIT]) |=>
      line_out_o[elaio_pkg::LINES-1:elaio_pkg::GROUP_W] ==
        $past(req_i.wdata[elaio_pkg::LINES-1:elaio_pkg::GROUP_W]))
    else $error("upper output group missed its written nibble");

  oe_dir_a: assert property (@(posedge ref_clk_i) // [R2]
    line_oe_o == {{elaio_pkg::GROUP_W{dir[elaio_pkg::DIR_UPPER_BIT]}},
      {elaio_pkg::GROUP_W{dir[elaio_pkg::DIR_LOWER_BIT]}}})
    else $error("drive enables do not follow the direction bits");

  dir_write_a: assert property (@(posedge ref_clk_i) // [R8]
    disable iff (rst_i)
    wr_dir |=> dir == $past(req_i.wdata[elaio_pkg::GROUPS-1:0]))
    else $error("direction write not stored");

  dir_hold_a: assert property (@(posedge ref_clk_i) // [R7]
    disable iff (rst_i)
    !wr_dir |=> $stable(dir))
    else $error("direction changed without a direction write");

  dir_read_a: assert property (@(posedge ref_clk_i) // [R7]
    disable iff (rst_i)
    (req_i.rd && hit_dir) |=> (rsp_o.valid &&
      rsp_o.rdata[elaio_pkg::GROUPS-1:0] == $past(dir)))
    else $error("direction read does not return stored bits");

  unmapped_read_a: assert property (@(posedge ref_clk_i) // [R9]
    disable iff (rst_i)
    (req_i.rd && !hit_dir && !hit_data) |=>
      rsp_o.rdata == elaio_pkg::READ_ZERO)
    else $error("unmapped read returned nonzero data");

  read_pulse_a: assert property (@(posedge ref_clk_i) // [R9]
    disable iff (rst_i)
    !req_i.rd |=> !rsp_o.valid)
    else $error("read answer without a read request");

  high_bytes_a: assert property (@(posedge ref_clk_i) // [R11]
    disable iff (rst_i)
    rsp_o.valid |->
      rsp_o.rdata[elaio_pkg::DATA_W-1:elaio_pkg::LINES] == '0)
    else $error("read answer carries bits above the eight lines");

  trig_gate_a: assert property (@(posedge ref_clk_i) // [R3]
    disable iff (rst_i)
    dir[elaio_pkg::DIR_LOWER_BIT] |=>
      (!extra_trigger_0_o && !extra_trigger_1_o))
    else $error("trigger tap active while lower group drives");

  ref_follow_a: assert property (@(posedge ref_clk_i) // [R4]
    disable iff (rst_i)
    !dir[elaio_pkg::DIR_LOWER_BIT] |=>
      timestamp_reference_clock_o == $past(pins[elaio_pkg::LINE_REFCLK]))
    else $error("reference clock tap does not follow its line");

  // only line 3 and the upper group may move here, so no tap may follow
  line3_free_a: assert property (@(posedge ref_clk_i) // [R5]
    disable iff (rst_i)
    (!$past(rst_i) && $stable(dir) &&
      $stable(pins[elaio_pkg::LINE_REFCLK:elaio_pkg::LINE_TRIG0])) |=>
      $stable({extra_trigger_0_o, extra_trigger_1_o,
        timestamp_reference_clock_o}))
    else $error("a tap moved although only line 3 changed");

  sample_hold_a: assert property (@(posedge ref_clk_i) // [R14]
    disable iff (rst_i)
    !capture |=> (!sample_valid_o && $stable(sample_data_o)))
    else $error("capture output moved without a trigger");

  reset_quiet_a: assert property (@(posedge ref_clk_i) // [R16]
    $past(rst_i) |-> (!rsp_o.valid && !sample_valid_o &&
      !extra_trigger_0_o && !extra_trigger_1_o &&
      !timestamp_reference_clock_o && line_out_o == elaio_pkg::DATA_RESET))
    else $error("outputs not quiet after reset");

endmodule

// ### verif/elaio_pins.sv
/*
  External instrument model standing on the eight port pins.
  Assumes the bench chooses the level the instrument drives.
*/
`timescale 1ns/1ps
module elaio_pins (
  input wire logic [7:0] line_out_i,   // port drive value
  input wire logic [7:0] line_oe_i,    // port drive enable
  input wire logic [7:0] inst_drive_i, // instrument level
  output logic [7:0] pin_o             // resolved pin level
);
  // the instrument yields wherever the port drives, so no contention
  assign pin_o = (line_oe_i & line_out_i) | (~line_oe_i & inst_drive_i);
endmodule

// ### verif/tb_top.sv
/*
  Self-checking bench for the eight-line auxiliary port.
  Assumes elaio_top and the pin model elaio_pins are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  elaio_pkg::elaio_req_t req_i = '0;
  elaio_pkg::elaio_rsp_t rsp_o;
  logic [7:0] line_in_i, line_out_o, line_oe_o, sample_data_o;
  logic [7:0] inst = 8'h00;
  logic [7:0] lat = 8'h00;
  logic [7:0] pins, oe;
  logic tap0, tap1, tref, sample_valid_o;
  logic ts_mode = 1'b0;
  logic auto_en = 1'b0;
  logic trig = 1'b0;
  logic [31:0] rq[$];
  logic [7:0] sq[$];
  logic [31:0] dv;
  logic [1:0] d;
  int seed = 93;
  int n_mismatch = 0;
  int n_tests = 0;
  localparam logic [15:0] A_DIR = elaio_pkg::LINE_GROUP_DIRECTION_ADDR;
  localparam logic [15:0] A_DATA = elaio_pkg::LINE_PIN_DATA_ADDR;

  always #25 ref_clk_i = ~ref_clk_i;

  elaio_top dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req_i),
    .rsp_o(rsp_o), .line_in_i(line_in_i), .line_out_o(line_out_o),
    .line_oe_o(line_oe_o), .extra_trigger_0_o(tap0),
    .extra_trigger_1_o(tap1), .timestamp_reference_clock_o(tref),
    .timestamp_mode_i(ts_mode), .auto_sample_en_i(auto_en),
    .trigger_event_i(trig), .sample_data_o(sample_data_o),
    .sample_valid_o(sample_valid_o));

  elaio_pins inst_model (.line_out_i(line_out_o), .line_oe_i(line_oe_o),
    .inst_drive_i(inst), .pin_o(line_in_i));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // request stays up over one rising edge; the next call replaces it
  task automatic bus(logic r, logic w, logic [15:0] a, logic [31:0] wd);
    @(negedge ref_clk_i);
    req_i = '{rd: r, wr: w, addr: a, wdata: wd};
  endtask

  task automatic rd(logic [15:0] a, logic [31:0] e);
    rq.push_back(e);
    bus(1'b1, 1'b0, a, 32'h0000_0000);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // result monitor
  // ----------------------------------------------------------------------
  always @(negedge ref_clk_i) begin
    if (!rst_i && rsp_o.valid === 1'b1) begin
      if (rq.size() == 0) chk("stray read", 0, 1);
      else chk("read data", rq.pop_front(), rsp_o.rdata);
    end
    if (!rst_i && sample_valid_o === 1'b1) begin
      if (sq.size() == 0) chk("stray sample", 0, 1);
      else chk("sample", {24'h0, sq.pop_front()},
        {24'h0, sample_data_o});
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    rd(A_DIR, 32'h0);
    bus(1'b0, 1'b0, 16'h0000, 32'h0);
    chk("reset oe", 0, {24'h0, line_oe_o});
    chk("reset drive", 0, {24'h0, line_out_o});
    ts_mode = 1'b1;
    for (int i = 0; i < 40; i++) begin
      dv = $random(seed);
      d = dv[1:0];
      bus(1'b0, 1'b1, A_DIR, dv);
      dv = $random(seed);
      bus(1'b0, 1'b1, A_DATA, dv);
      for (int g = 0; g < 2; g++) if (d[g]) lat[g*4 +: 4] = dv[g*4 +: 4];
      bus(1'b0, 1'b0, 16'h0000, 32'h0);
      dv = $random(seed);
      inst = dv[7:0];
      oe = {{4{d[1]}}, {4{d[0]}}};
      pins = (oe & lat) | (~oe & inst);
      repeat (5) @(negedge ref_clk_i);
      chk("oe", {24'h0, oe}, {24'h0, line_oe_o});
      chk("drive", {24'h0, lat}, {24'h0, line_out_o});
      chk("trig0", {31'h0, ~d[0] & pins[0]}, {31'h0, tap0});
      chk("trig1", {31'h0, ~d[0] & pins[1]}, {31'h0, tap1});
      chk("refclk", {31'h0, ~d[0] & pins[2]}, {31'h0, tref});
      rd(A_DIR, {30'h0, d});
      rd(A_DATA, {24'h0, pins});
      rd(16'hB800, 32'h0);
      bus(1'b0, 1'b0, 16'h0000, 32'h0);
      dv = $random(seed);
      auto_en = dv[0];
      trig = 1'b1;
      if (auto_en) sq.push_back(pins);
      @(negedge ref_clk_i);
      trig = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      $display("test %0d done", i);
    end
    repeat (5) @(negedge ref_clk_i);
    chk("pending", 0, rq.size() + sq.size());
    complete_run();
  end
endmodule
